// *** tmg_pkg.sv ***
// Constants and types for the timer event generator and channel mode block.
// Assumes a 16-bit register port inside a timer running on one kernel clock.
`default_nettype none

package tmg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] TMG_OFS_EVENT = 8'h14;
    localparam logic [7:0] TMG_OFS_MODE = 8'h18;
    localparam logic [7:0] TMG_OFS_CMP1 = 8'h34;
    localparam logic [7:0] TMG_OFS_CMP2 = 8'h38;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TMG_BIT_UPDATE = 0;
    localparam int TMG_BIT_CH1_EVENT = 1;
    localparam int TMG_BIT_CONTROL_UPDATE = 5;
    localparam int TMG_BIT_TRIGGER = 6;
    localparam int TMG_BIT_BREAK = 7;
    localparam logic [15:0] TMG_EVENT_MASK = 16'h00e7;
    localparam int TMG_CH_STRIDE = 8;
    localparam int TMG_POS_DIR = 0;
    localparam int TMG_POS_FAST = 2;
    localparam int TMG_POS_PRELOAD = 3;
    localparam int TMG_POS_MODE = 4;

    // ************************************************************
    // Reset values and codes
    // ************************************************************
    localparam logic [15:0] TMG_RST_EVENT = 16'h0000;
    localparam logic [7:0] TMG_RST_CH_CFG = 8'h00;
    localparam logic [15:0] TMG_RST_CMP = 16'h0000;
    localparam logic [1:0] TMG_DIR_OUTPUT = 2'h0;
    localparam logic [1:0] TMG_DIR_OWN = 2'h1;
    localparam logic [1:0] TMG_DIR_OTHER = 2'h2;
    localparam logic [1:0] TMG_DIR_INTERNAL = 2'h3;
    localparam logic [1:0] TMG_LOCK_FULL = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int TMG_TRIG_NORMAL_MIN_CYC = 5;
    localparam int TMG_TRIG_FAST_MAX_CYC = 3;
    // Counter pipeline depth that keeps the normal path at its minimum delay
    localparam int TMG_CNT_PIPE = TMG_TRIG_NORMAL_MIN_CYC - 2;

    typedef enum logic [2:0] {
        TMG_OM_FROZEN = 3'h0,
        TMG_OM_SET = 3'h1,
        TMG_OM_CLEAR = 3'h2,
        TMG_OM_TOGGLE = 3'h3,
        TMG_OM_FORCE_LOW = 3'h4,
        TMG_OM_FORCE_HIGH = 3'h5,
        TMG_OM_PWM1 = 3'h6,
        TMG_OM_PWM2 = 3'h7
    } tmg_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tmg_req_s;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic down;
        logic center;
    } tmg_base_s;

endpackage

`default_nettype wire

// *** tmg_event_mode.sv ***
// Software event generation and two-channel capture/compare mode logic.
// Assumes counter, status flags, enables and lock level live in the timer around it.
//
// Operation
// - Event request bits self-clear; zero writes ignored
// - Break request clears output enable, flags break
// - Trigger request sets trigger flag
// - Control update transfers when control preload set
// - Output channel event request sets compare flag
// - Input channel request captures counter, may overcapture
// - Update request reloads counter, registers, prescaler
// - Counter zero up/center, reload value down
// - Channel 1 direction field selects input mapping
// - Channel 2 direction field selects input mapping
// - Direction writable only while channel disabled
// - Frozen, set, clear, toggle on match
// - Forced low and forced high modes
// - PWM mode 1 levels by count direction
// - PWM mode 2 inverts mode 1
// - PWM level moves only with comparison; fast trigger also forces it
// - Lock level 3 protects output mode, preload
// - Compare preload decides immediate or update transfer
// - Normal trigger path at least five cycles
// - Fast trigger reaches output within three cycles
// - Software update flags only without source/disable
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module tmg_event_mode
    import tmg_pkg::*;
(
    input wire logic core_clk_i, // Timer kernel clock, 20 MHz
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire tmg_req_s bus_req_i, // Register request
    output logic [15:0] bus_rdata_o, // Read data, cycle after read
    input wire tmg_base_s base_i, // Counter state
    input wire logic [1:0] channel_enable_i, // Per-channel enable
    input wire logic [1:0] lock_level_i, // Protection level
    input wire logic control_preload_i, // Control preload set
    input wire logic update_source_select_i, // Update source restriction
    input wire logic update_disable_i, // Update events disabled
    input wire logic update_event_i, // Update from counter overflow
    input wire logic [1:0] ch_event_flag_i, // Channel event flags now
    input wire logic trigger_pulse_i, // Active trigger edge pulse
    input wire logic internal_trigger_input_i, // Internal trigger level
    input wire logic timer_input_one_i, // Pin, asynchronous
    input wire logic timer_input_two_i, // Pin, asynchronous
    output logic break_event_o, // Break pulse
    output logic main_output_enable_clear_o, // Clear output enable pulse
    output logic break_flag_set_o, // Set break flag pulse
    output logic trigger_flag_set_o, // Set trigger flag pulse
    output logic control_update_o, // Transfer control bits pulse
    output logic update_event_o, // Software update pulse
    output logic update_flag_set_o, // Set update flag pulse
    output logic counter_reload_o, // Load counter pulse
    output logic [15:0] counter_load_value_o, // Value to load
    output logic prescaler_clear_o, // Clear prescaler counter pulse
    output logic [1:0] ch_event_flag_set_o, // Set channel event flag
    output logic [1:0] ch_overcapture_flag_set_o, // Set overcapture flag
    output logic [1:0] ch_output_reference_o // Output references
);

    // ************************************************************
    // Decode and event register
    // ************************************************************
    logic wr_event, wr_mode;
    logic [15:0] event_q;
    logic trig_q;
    logic upd_any;

    assign wr_event = bus_req_i.wr && (bus_req_i.addr == TMG_OFS_EVENT);
    assign wr_mode = bus_req_i.wr && (bus_req_i.addr == TMG_OFS_MODE);
    assign upd_any = event_q[TMG_BIT_UPDATE] || update_event_i;

    // Bits hold one cycle, then clear; a later zero write cannot cancel them
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            event_q <= TMG_RST_EVENT;
        end else if (wr_event) begin
            event_q <= bus_req_i.wdata & TMG_EVENT_MASK;
        end else begin
            event_q <= TMG_RST_EVENT;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            break_event_o <= 1'b0;
            main_output_enable_clear_o <= 1'b0;
            break_flag_set_o <= 1'b0;
            trigger_flag_set_o <= 1'b0;
            control_update_o <= 1'b0;
        end else begin
            break_event_o <= event_q[TMG_BIT_BREAK];
            main_output_enable_clear_o <= event_q[TMG_BIT_BREAK];
            break_flag_set_o <= event_q[TMG_BIT_BREAK];
            trigger_flag_set_o <= event_q[TMG_BIT_TRIGGER];
            control_update_o <= event_q[TMG_BIT_CONTROL_UPDATE] && control_preload_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            update_event_o <= 1'b0;
            update_flag_set_o <= 1'b0;
            counter_reload_o <= 1'b0;
            counter_load_value_o <= TMG_RST_CMP;
            prescaler_clear_o <= 1'b0;
        end else begin
            update_event_o <= event_q[TMG_BIT_UPDATE];
            counter_reload_o <= event_q[TMG_BIT_UPDATE];
            prescaler_clear_o <= event_q[TMG_BIT_UPDATE];
            update_flag_set_o <= event_q[TMG_BIT_UPDATE] && !update_source_select_i
                && !update_disable_i;
            if (base_i.center || !base_i.down) begin
                counter_load_value_o <= TMG_RST_CMP;
            end else begin
                counter_load_value_o <= base_i.reload;
            end
        end
    end

    // ************************************************************
    // Shared pipelines and pin synchronisers
    // ************************************************************
    // Counter is delayed so a trigger restart cannot reach the output early
    logic [15:0] cnt_pipe_q [TMG_CNT_PIPE];
    logic down_pipe_q [TMG_CNT_PIPE];
    logic [1:0] ti_meta_q, ti_sync_q;
    logic itr_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < TMG_CNT_PIPE; i++) begin
                cnt_pipe_q[i] <= TMG_RST_CMP;
                down_pipe_q[i] <= 1'b0;
            end
        end else begin
            cnt_pipe_q[0] <= base_i.count;
            down_pipe_q[0] <= base_i.down;
            for (int i = 1; i < TMG_CNT_PIPE; i++) begin
                cnt_pipe_q[i] <= cnt_pipe_q[i-1];
                down_pipe_q[i] <= down_pipe_q[i-1];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ti_meta_q <= 2'h0;
            ti_sync_q <= 2'h0;
            trig_q <= 1'b0;
            itr_q <= 1'b0;
        end else begin
            ti_meta_q <= {timer_input_two_i, timer_input_one_i};
            ti_sync_q <= ti_meta_q;
            trig_q <= trigger_pulse_i;
            itr_q <= internal_trigger_input_i;
        end
    end

    // ************************************************************
    // Per-channel mode, compare and reference
    // ************************************************************
    logic [7:0] cfg_q [2];
    logic [15:0] cmp_pre_q [2];
    logic [15:0] cmp_act_q [2];
    logic ref_q [2];
    logic ev_set_q [2];
    logic ovc_set_q [2];

    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic [1:0] dir;
        logic fast, pre;
        tmg_mode_e mode;
        logic is_out, lock_out, sel_lvl, sel_prev_q, edge_cap, sw_ev, capture;
        logic wr_cmp;
        logic [7:0] wbyte;
        logic match, lt, gt, pwm1;

        assign dir = cfg_q[g][TMG_POS_DIR +: 2];
        assign fast = cfg_q[g][TMG_POS_FAST];
        assign pre = cfg_q[g][TMG_POS_PRELOAD];
        assign mode = tmg_mode_e'(cfg_q[g][TMG_POS_MODE +: 3]);
        assign is_out = (dir == TMG_DIR_OUTPUT);
        assign lock_out = (lock_level_i == TMG_LOCK_FULL) && is_out;
        assign wbyte = bus_req_i.wdata[TMG_CH_STRIDE*g +: TMG_CH_STRIDE];
        assign wr_cmp = bus_req_i.wr && (bus_req_i.addr == ((g == 0) ? TMG_OFS_CMP1 : TMG_OFS_CMP2));
        assign sw_ev = event_q[TMG_BIT_CH1_EVENT + g];

        // Own pin, other pin or internal trigger
        always_comb begin
            case (dir)
                TMG_DIR_OWN: sel_lvl = ti_sync_q[g];
                TMG_DIR_OTHER: sel_lvl = ti_sync_q[1-g];
                TMG_DIR_INTERNAL: sel_lvl = itr_q;
                default: sel_lvl = 1'b0;
            endcase
        end

        assign edge_cap = !is_out && channel_enable_i[g] && sel_lvl && !sel_prev_q;
        assign capture = !is_out && (sw_ev || edge_cap);

        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                cfg_q[g] <= TMG_RST_CH_CFG;
            end else if (wr_mode) begin
                if (!channel_enable_i[g]) begin
                    cfg_q[g][TMG_POS_DIR +: 2] <= wbyte[TMG_POS_DIR +: 2];
                end
                cfg_q[g][TMG_POS_FAST] <= wbyte[TMG_POS_FAST];
                if (!lock_out) begin
                    cfg_q[g][TMG_POS_PRELOAD] <= wbyte[TMG_POS_PRELOAD];
                    cfg_q[g][TMG_POS_MODE +: 3] <= wbyte[TMG_POS_MODE +: 3];
                end
            end
        end

        // Capture overwrites the active copy, which then reads as the capture value
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                cmp_pre_q[g] <= TMG_RST_CMP;
                cmp_act_q[g] <= TMG_RST_CMP;
            end else begin
                if (wr_cmp && is_out) begin
                    cmp_pre_q[g] <= bus_req_i.wdata;
                end
                if (capture) begin
                    cmp_act_q[g] <= base_i.count;
                end else if (wr_cmp && is_out && !pre) begin
                    cmp_act_q[g] <= bus_req_i.wdata;
                end else if (upd_any && pre) begin
                    cmp_act_q[g] <= cmp_pre_q[g];
                end
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                sel_prev_q <= 1'b0;
                ev_set_q[g] <= 1'b0;
                ovc_set_q[g] <= 1'b0;
            end else begin
                sel_prev_q <= sel_lvl;
                ev_set_q[g] <= (is_out && sw_ev) || capture;
                ovc_set_q[g] <= capture && ch_event_flag_i[g];
            end
        end

        assign match = cnt_pipe_q[TMG_CNT_PIPE-1] == cmp_act_q[g];
        assign lt = cnt_pipe_q[TMG_CNT_PIPE-1] < cmp_act_q[g];
        assign gt = cnt_pipe_q[TMG_CNT_PIPE-1] > cmp_act_q[g];
        assign pwm1 = down_pipe_q[TMG_CNT_PIPE-1] ? !gt : lt;

        // PWM levels follow the comparison each cycle, except that with fast set trig_q forces the level that a match leaves
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                ref_q[g] <= 1'b0;
            end else if (!is_out) begin
                ref_q[g] <= 1'b0;
            end else begin
                case (mode)
                    TMG_OM_FROZEN: ref_q[g] <= ref_q[g];
                    TMG_OM_SET: ref_q[g] <= match ? 1'b1 : ref_q[g];
                    TMG_OM_CLEAR: ref_q[g] <= match ? 1'b0 : ref_q[g];
                    TMG_OM_TOGGLE: ref_q[g] <= match ? !ref_q[g] : ref_q[g];
                    TMG_OM_FORCE_LOW: ref_q[g] <= 1'b0;
                    TMG_OM_FORCE_HIGH: ref_q[g] <= 1'b1;
                    TMG_OM_PWM1: ref_q[g] <= (fast && trig_q) ? 1'b0 : pwm1;
                    TMG_OM_PWM2: ref_q[g] <= (fast && trig_q) ? 1'b1 : !pwm1;
                    default: ref_q[g] <= 1'b0;
                endcase
            end
        end
    end

    assign ch_output_reference_o = {ref_q[1], ref_q[0]};
    assign ch_event_flag_set_o = {ev_set_q[1], ev_set_q[0]};
    assign ch_overcapture_flag_set_o = {ovc_set_q[1], ovc_set_q[0]};

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= TMG_RST_EVENT;
        end else if (!bus_req_i.rd) begin
            bus_rdata_o <= TMG_RST_EVENT;
        end else begin
            case (bus_req_i.addr)
                TMG_OFS_EVENT: bus_rdata_o <= TMG_RST_EVENT;
                TMG_OFS_MODE: bus_rdata_o <= {1'b0, cfg_q[1][6:0], 1'b0, cfg_q[0][6:0]};
                TMG_OFS_CMP1: bus_rdata_o <= (cfg_q[0][TMG_POS_PRELOAD] && g_ch[0].is_out) ? cmp_pre_q[0]
                    : cmp_act_q[0];
                TMG_OFS_CMP2: bus_rdata_o <= (cfg_q[1][TMG_POS_PRELOAD] && g_ch[1].is_out) ? cmp_pre_q[1]
                    : cmp_act_q[1];
                default: bus_rdata_o <= TMG_RST_EVENT;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_event_self_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_event ##1 !wr_event) |=> (event_q == TMG_RST_EVENT);
    endproperty
    a_event_self_clear: assert property (p_event_self_clear) else $error("event bits did not clear");

    property p_break;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_event && bus_req_i.wdata[TMG_BIT_BREAK]) |-> ##2 (main_output_enable_clear_o && break_flag_set_o);
    endproperty
    a_break: assert property (p_break) else $error("break request lost");

    property p_trigger;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_event && bus_req_i.wdata[TMG_BIT_TRIGGER]) |-> ##2 trigger_flag_set_o ##1 !trigger_flag_set_o;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger flag pulse wrong");

    property p_control_update;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        event_q[TMG_BIT_CONTROL_UPDATE] |=> (control_update_o == $past(control_preload_i));
    endproperty
    a_control_update: assert property (p_control_update) else $error("control update mismatch");

    property p_overcapture;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (event_q[TMG_BIT_CH1_EVENT] && !g_ch[0].is_out && ch_event_flag_i[0])
            |=> (ch_overcapture_flag_set_o[0] && ch_event_flag_set_o[0]);
    endproperty
    a_overcapture: assert property (p_overcapture) else $error("overcapture not flagged");

    property p_reload_value;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (event_q[TMG_BIT_UPDATE] && base_i.down && !base_i.center)
            |=> (counter_reload_o && counter_load_value_o == $past(base_i.reload));
    endproperty
    a_reload_value: assert property (p_reload_value) else $error("down count reload wrong");

    property p_dir_locked;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_mode && channel_enable_i[0]) |=> $stable(cfg_q[0][TMG_POS_DIR +: 2]);
    endproperty
    a_dir_locked: assert property (p_dir_locked) else $error("direction changed while enabled");

    property p_mode_lock;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_mode && lock_level_i == TMG_LOCK_FULL && g_ch[1].is_out) |=> $stable(cfg_q[1][6:3]);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("locked mode bits changed");

    property p_force_low;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (g_ch[0].is_out && g_ch[0].mode == TMG_OM_FORCE_LOW) |=> !ch_output_reference_o[0];
    endproperty
    a_force_low: assert property (p_force_low) else $error("forced low not held");

    property p_fast;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        // Both PWM modes: the low mode bit is the level that a match leaves behind
        (trigger_pulse_i && g_ch[0].is_out && g_ch[0].fast && g_ch[0].mode[2:1] == 2'h3)
            |-> ##[1:3] (ch_output_reference_o[0] == g_ch[0].mode[0]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast trigger too slow");

    property p_reserved_zero;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (bus_req_i.rd && bus_req_i.addr == TMG_OFS_MODE) |=> (!bus_rdata_o[15] && !bus_rdata_o[7]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");

    property p_update_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (event_q[TMG_BIT_UPDATE] && (update_source_select_i || update_disable_i)) |=> !update_flag_set_o;
    endproperty
    a_update_flag: assert property (p_update_flag) else $error("update flag set while suppressed");

endmodule // tmg_event_mode

`default_nettype wire

// *** tmg_pins_model.sv ***
// Far-side model: trigger edge source and the two timer input pins.
// Assumes one-bit commands from the bench, sampled on the kernel clock.
`timescale 1ns/1ps
`default_nettype none
module tmg_pins_model (
    input wire logic clk_i, // Kernel clock
    input wire logic trig_cmd_i, // Ask for one trigger edge
    input wire logic [1:0] pin_cmd_i, // Wanted levels of inputs one and two
    output logic trig_o, // Active trigger edge pulse
    output logic ti_one_o, // Timer input one
    output logic ti_two_o // Timer input two
);
    // Edge pulse lasts one cycle; a held command repeats it every second cycle
    always_ff @(posedge clk_i) begin
        trig_o <= trig_cmd_i & ~trig_o;
        ti_one_o <= pin_cmd_i[0];
        ti_two_o <= pin_cmd_i[1];
    end
endmodule // tmg_pins_model
`default_nettype wire

// *** timer_event_gen_and_channel_mode_tb.sv ***
// Self-checking bench of the event and channel mode block.
// Assumes tmg_pkg and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timer_event_gen_and_channel_mode_tb;
    import tmg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tmg_req_s req = '0;
    tmg_base_s base = '0;
    logic [1:0] en = 2'h0, lock = 2'h0, flg = 2'h0, pcmd = 2'h0, evs, ocs, oref;
    logic cp = 1'b0, uss = 1'b0, ud = 1'b0, tcmd = 1'b0, itr = 1'b0, uevt = 1'b0;
    logic trig, ti1, ti2, bev, moec, bfs, tfs, cu, uev, ufs, crl, pcl;
    logic [15:0] rdata, lval, pv, v;
    logic [15:0] mode_m = 16'h0000;
    int bad_count = 0, total_checks = 0, cyc = 0, e, b;
    assign pv = {7'h00, bev, moec, bfs, tfs, cu, uev, ufs, crl, pcl};
    initial begin
        forever #25 clk = ~clk;
    end
    tmg_event_mode dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .bus_req_i(req), .bus_rdata_o(rdata),
        .base_i(base), .channel_enable_i(en), .lock_level_i(lock), .control_preload_i(cp),
        .update_source_select_i(uss), .update_disable_i(ud), .update_event_i(uevt),
        .ch_event_flag_i(flg), .trigger_pulse_i(trig), .internal_trigger_input_i(itr),
        .timer_input_one_i(ti1), .timer_input_two_i(ti2), .break_event_o(bev),
        .main_output_enable_clear_o(moec), .break_flag_set_o(bfs), .trigger_flag_set_o(tfs),
        .control_update_o(cu), .update_event_o(uev), .update_flag_set_o(ufs), .counter_reload_o(crl),
        .counter_load_value_o(lval), .prescaler_clear_o(pcl), .ch_event_flag_set_o(evs),
        .ch_overcapture_flag_set_o(ocs), .ch_output_reference_o(oref));
    tmg_pins_model pins_u (.clk_i(clk), .trig_cmd_i(tcmd), .pin_cmd_i(pcmd), .trig_o(trig),
        .ti_one_o(ti1), .ti_two_o(ti2));
    // ************************************************************
    // Bus tasks, model and checks
    // ************************************************************
    task automatic end_of_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk("rdata", rdata, x);
    endtask
    function automatic logic [15:0] nm(input logic [15:0] o, input logic [15:0] w);
        logic [15:0] n;
        n = w & 16'h7f7f;
        for (int c = 0; c < 2; c++) begin
            if (en[c]) n[8*c +: 2] = o[8*c +: 2];
            if (lock == TMG_LOCK_FULL && o[8*c +: 2] == TMG_DIR_OUTPUT) n[8*c+3 +: 4] = o[8*c+3 +: 4];
        end
        return n;
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        v = 16'($urandom(2786));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(TMG_OFS_EVENT, TMG_RST_EVENT);
        rd(TMG_OFS_MODE, 16'h0000);
        rd(8'h40, 16'h0000);
        // Index 8 writes zero, 3 and 4 hit reserved bits; 9 updates again, suppressed and centred
        for (e = 0; e < 10; e++) begin
            b = e % 9;
            @(posedge clk);
            base <= '{count: 16'($urandom), reload: 16'($urandom), down: e == 0 || 1'($urandom), center: e == 9};
            cp <= 1'($urandom);
            uss <= e == 9 || 1'($urandom);
            ud <= 1'($urandom);
            wr(TMG_OFS_EVENT, (b == 8) ? 16'h0000 : 16'h0001 << b);
            @(posedge clk);
            #1 chk("pulses", pv, {7'h00, {3{b == 7}}, b == 6, b == 5 && cp, b == 0, b == 0 && !uss && !ud,
                b == 0, b == 0});
            chk("ch_evt", {14'h0, evs}, {14'h0, b == 2, b == 1});
            if (b == 0) chk("load", lval, (base.down && !base.center) ? base.reload : 16'h0000);
            @(posedge clk);
            #1 chk("selfclr", pv | {14'h0, evs}, 16'h0000);
        end
        for (e = 0; e < 6; e++) begin
            @(posedge clk);
            en <= 2'($urandom);
            lock <= (e < 3) ? TMG_LOCK_FULL : 2'($urandom);
            v = 16'($urandom);
            wr(TMG_OFS_MODE, v);
            mode_m = nm(mode_m, v);
            rd(TMG_OFS_MODE, mode_m);
        end
        @(posedge clk);
        en <= 2'h0;
        lock <= 2'h0;
        flg <= 2'h1;
        wr(TMG_OFS_MODE, 16'h0001);
        wr(TMG_OFS_EVENT, 16'h0002);
        @(posedge clk);
        #1 chk("cap", {12'h0, ocs, evs}, 16'h0005);
        rd(TMG_OFS_CMP1, base.count);
        // Second pass maps channel 1 to input two and channel 2 to the internal trigger,
        // whose source the surrounding timer is taken to have chosen
        for (e = 0; e < 2; e++) begin
            @(posedge clk);
            flg <= 2'h0;
            en <= 2'h0;
            wr(TMG_OFS_MODE, e[0] ? 16'h0302 : 16'h0201);
            @(posedge clk);
            en <= 2'h3;
            pcmd <= {e[0], 1'b1};
            itr <= e[0];
            v = 16'h0000;
            repeat (8) begin
                @(posedge clk);
                #1 v[1:0] = v[1:0] | evs;
            end
            chk("pin_cap", v, 16'h0003);
        end
        @(posedge clk);
        en <= 2'h0;
        base <= '{count: 16'h0032, reload: 16'h00ff, down: 1'b0, center: 1'b0};
        wr(TMG_OFS_MODE, 16'h0000);
        wr(TMG_OFS_CMP1, 16'h0064);
        for (e = 4; e < 8; e++) begin
            wr(TMG_OFS_MODE, 16'(e << 4));
            repeat (6) @(posedge clk);
            #1 chk("ref", {15'h0, oref[0]}, 16'(e == 5 || e == 6));
        end
        // Preloaded compare waits for the software update
        wr(TMG_OFS_MODE, 16'h0068);
        wr(TMG_OFS_CMP1, 16'h0010);
        rd(TMG_OFS_CMP1, 16'h0010);
        repeat (6) @(posedge clk);
        #1 chk("pre_hold", {15'h0, oref[0]}, 16'h0001);
        wr(TMG_OFS_EVENT, 16'h0001);
        repeat (6) @(posedge clk);
        #1 chk("pre_load", {15'h0, oref[0]}, 16'h0000);
        // Hardware update moves the preload copy as well
        wr(TMG_OFS_CMP1, 16'h0064);
        @(posedge clk);
        uevt <= 1'b1;
        @(posedge clk);
        uevt <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk("hw_upd", {15'h0, oref[0]}, 16'h0001);
        @(posedge clk);
        base.count <= 16'h0008;
        wr(TMG_OFS_MODE, 16'h006c);
        repeat (6) @(posedge clk);
        tcmd <= 1'b1;
        @(posedge clk);
        tcmd <= 1'b0;
        v = 16'h0001;
        repeat (3) begin
            @(posedge clk);
            #1 v[0] = v[0] & oref[0];
        end
        chk("fast", v, 16'h0000);
        // Counter parked on the compare value: frozen holds, set, clear, toggle each cycle
        @(posedge clk);
        base.count <= 16'h0064;
        for (e = 0; e < 4; e++) begin
            wr(TMG_OFS_MODE, 16'(e << 4));
            repeat (6) @(posedge clk);
            #1 v[0] = oref[0];
            @(posedge clk);
            #1 chk("match", {15'h0, oref[0]}, 16'(e == 1 || (e == 3 && !v[0]) || (e == 0 && v[0])));
        end
        end_of_test();
    end
endmodule // timer_event_gen_and_channel_mode_tb
`default_nettype wire
